// [rtl/external_controller_request_params.svh]
// constants shared by both ends of the interrupt entry link
// assumes inclusion by bare name from rtl/
`ifndef EXTERNAL_CONTROLLER_REQUEST_PARAMS_SVH
`define EXTERNAL_CONTROLLER_REQUEST_PARAMS_SVH
// fixed restart vectors
`define VEC_NONMASK     16'h0024
`define VEC_EDGE        16'h003C
`define VEC_LEVEL_HIGH  16'h0034
`define VEC_LEVEL_LOW   16'h002C
// controller answer bytes and commands
`define CALL_OPCODE     8'hCD
`define EOS_CMD         8'h20
`define READ_PEND_CMD   8'h0A
`define READ_INSV_CMD   8'h0B
// set_mask_instruction field positions
`define SMI_MASK_LSB    0
`define SMI_MASK_EN     3
`define SMI_EDGE_CLR    4
// read_mask_instruction field positions
`define RMI_IE          3
`define RMI_PEND_LSB    4
// controller register byte offsets on AXI4-Lite
`define OFS_OPWORD      4'h0
`define OFS_LINE_MASK   4'h4
`define AXI_OKAY        2'h0
`define AXI_SLVERR      2'h2
// reset values; ACK_BYTES is the index of the last acknowledge byte
`define LINE_MASK_RST   8'hFF
`define CPU_MASK_RST    3'h7
`define ACK_BYTES       2'h2
`endif

// [rtl/external_controller_request_pkg.sv]
// types for the interrupt entry link and both of its ends
// assumes external_controller_request_params.svh sits beside it
package external_controller_request_pkg;
  typedef enum logic [1:0] {A_IDLE, A_PUSH, A_STROBE, A_SAMPLE} ack_state_t;

  typedef struct packed {
    logic [3:0]  sync1;
    logic [3:0]  sync2;
    logic [1:0]  last2;
    logic        nmi_pend;
    logic        edge_pend;
    logic        ie;
    logic [2:0]  mask;
    logic        trap_flag;
    logic        trap_ie;
    ack_state_t  st;
    logic [1:0]  nbyte;
    logic        ack_n;
    logic        taken;
    logic [15:0] vector;
    logic        push_pc;
    logic        done;
    logic [7:0]  opcode;
    logic [15:0] target;
    logic [7:0]  rim_data;
  } cpu_state_t;

  typedef struct packed {
    logic [7:0]  sync1;
    logic [7:0]  sync2;
    logic [7:0]  mask;
    logic [7:0]  in_service_reg;
    logic        read_isr;
    logic [1:0]  byte_idx;
    logic [2:0]  line;
    logic [7:0]  data;
    logic        req;
    logic        awready;
    logic        wready;
    logic        aw_hold;
    logic [1:0]  aw_sel;
    logic        w_hold;
    logic [7:0]  wdata;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } ctrl_state_t;
endpackage

// [rtl/external_controller_request_link_if.sv]
// link between processor entry logic and the priority controller
// assumes both ends share aclk; the bench instantiates it
`timescale 1ns/100ps
interface external_controller_request_link_if;
  logic       request;
  logic       ack_strobe_n;
  logic [7:0] data;
  modport cpu_end  (input request, input data, output ack_strobe_n);
  modport ctrl_end (output request, output data, input ack_strobe_n);
endinterface

// [rtl/cpu_interrupt_entry.sv]
// processor-side interrupt entry: restart inputs, priority, acknowledge
// assumes controller on same clock; restart pins are asynchronous
`timescale 1ns/100ps
`include "external_controller_request_params.svh"
module cpu_interrupt_entry (
  // clock, reset, enable
  input  wire  logic        aclk,
  input  wire  logic        aresetn,
  input  wire  logic        clk_en,
  // asynchronous interrupt pins
  input  wire  logic        nonmaskable_request,
  input  wire  logic        edge_restart_request,
  input  wire  logic        level_restart_high,
  input  wire  logic        level_restart_low,
  // controller link
  external_controller_request_link_if.cpu_end      link,
  // instruction sequencer side
  input  wire  logic        instr_last_cycle,
  input  wire  logic        enable_set,
  input  wire  logic        enable_clear,
  input  wire  logic        set_mask_instruction,
  input  wire  logic [7:0]  set_mask_data,
  input  wire  logic        read_mask_instruction,
  // results
  output logic              restart_taken,
  output logic [15:0]       restart_vector,
  output logic              push_pc,
  output logic              call_done,
  output logic [7:0]        call_opcode,
  output logic [15:0]       call_target,
  output logic [7:0]        read_mask_data,
  output logic              interrupt_enable
);
  import external_controller_request_pkg::*;

  cpu_state_t s;
  cpu_state_t n;
  logic       nmi_rise;
  logic       edge_rise;
  logic       accept;

  //////////////////////////////////////////////////////////////////////
  always_comb begin
    n         = s;
    accept    = 1'b0;
    // pins enter through two flops; first stage feeds only the second
    n.sync1   = {nonmaskable_request, edge_restart_request,
                 level_restart_high, level_restart_low};
    n.sync2   = s.sync1;
    n.last2   = s.sync2[3:2];
    nmi_rise  = s.sync2[3] & ~s.last2[1];
    edge_rise = s.sync2[2] & ~s.last2[0];
    n.taken   = 1'b0;
    n.push_pc = 1'b0;
    n.done    = 1'b0;

    if (enable_set) begin
      n.ie = 1'b1;
    end else if (enable_clear) begin
      n.ie = 1'b0;
    end

    if (set_mask_instruction) begin
      if (set_mask_data[`SMI_MASK_EN]) begin
        n.mask = set_mask_data[`SMI_MASK_LSB +: 3];
      end
      if (set_mask_data[`SMI_EDGE_CLR]) begin
        n.edge_pend = 1'b0;
      end
    end

    if (read_mask_instruction) begin
      n.rim_data = 8'h00;
      n.rim_data[`SMI_MASK_LSB +: 3] = s.mask;
      n.rim_data[`RMI_IE] = s.trap_flag ? s.trap_ie : s.ie;
      n.rim_data[`RMI_PEND_LSB +: 3] = {s.edge_pend, s.sync2[1:0]};
      n.trap_flag = 1'b0;
    end

    // every restart is taken at an instruction boundary only
    if (s.st == A_IDLE && instr_last_cycle) begin
      if (s.nmi_pend) begin
        // nonmaskable path is not gated by ie or mask; it saves ie into trap_ie, then clears ie like the others
        accept      = 1'b1;
        n.vector    = `VEC_NONMASK;
        n.nmi_pend  = 1'b0;
        n.trap_ie   = s.ie;
        n.trap_flag = 1'b1;
      end else if (s.ie && s.edge_pend && !s.mask[2]) begin
        accept      = 1'b1;
        n.vector    = `VEC_EDGE;
        n.edge_pend = 1'b0;
      end else if (s.ie && s.sync2[1] && !s.mask[1]) begin
        accept      = 1'b1;
        n.vector    = `VEC_LEVEL_HIGH;
      end else if (s.ie && s.sync2[0] && !s.mask[0]) begin
        accept      = 1'b1;
        n.vector    = `VEC_LEVEL_LOW;
      end else if (s.ie && link.request) begin
        n.st        = A_PUSH;
        n.ie        = 1'b0;
      end
      if (accept) begin
        n.taken = 1'b1;
        // no record of which routine runs: next enable reopens all
        n.ie    = 1'b0;
      end
    end

    // a fresh edge in the clearing cycle is kept
    if (nmi_rise) begin
      n.nmi_pend = 1'b1;
    end
    if (edge_rise) begin
      n.edge_pend = 1'b1;
    end

    case (s.st)
      A_PUSH: begin
        n.push_pc = 1'b1;
        // all ones: no strobe answered yet
        n.nbyte   = 2'h3;
        n.st      = A_STROBE;
      end
      A_STROBE: begin
        // controller byte stands from the cycle after its strobe through the next strobe
        if (s.nbyte == 2'h0) begin
          n.opcode = link.data;
        end else if (s.nbyte == 2'h1) begin
          n.target[7:0] = link.data;
        end else if (s.nbyte == 2'h2) begin
          n.target[15:8] = link.data;
        end
        if (s.nbyte == `ACK_BYTES) begin
          n.done = 1'b1;
          n.st   = A_IDLE;
        end else begin
          n.ack_n = 1'b0;
          n.st    = A_SAMPLE;
        end
      end
      A_SAMPLE: begin
        n.ack_n = 1'b1;
        n.nbyte = s.nbyte + 2'h1;
        n.st    = A_STROBE;
      end
      default: begin
        n.ack_n = 1'b1;
      end
    endcase

    if (!clk_en) begin
      n = s;
    end
  end

  //////////////////////////////////////////////////////////////////////
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s       <= '0;
      s.ack_n <= 1'b1;
      s.st    <= A_IDLE;
      s.mask  <= `CPU_MASK_RST;
    end else begin
      s <= n;
    end
  end

  assign link.ack_strobe_n = s.ack_n;
  assign restart_taken     = s.taken;
  assign restart_vector    = s.vector;
  assign push_pc           = s.push_pc;
  assign call_done         = s.done;
  assign call_opcode       = s.opcode;
  assign call_target       = s.target;
  assign read_mask_data    = s.rim_data;
  assign interrupt_enable  = s.ie;
endmodule

// [rtl/priority_controller.sv]
// priority controller end: eight request lines, AXI4-Lite host port
// assumes same aclk as the processor end; lines are asynchronous
//
// Design decisions made here: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`include "external_controller_request_params.svh"
module priority_controller #(
  parameter int LINES  = 8,
  parameter int ADDR_W = 4
) (
  // clock, reset, enable
  input  wire  logic              aclk,
  input  wire  logic              aresetn,
  input  wire  logic              clk_en,
  // request lines and routine placement
  input  wire  logic [LINES-1:0]  request_lines,
  input  wire  logic [15:0]       vector_base,
  input  wire  logic              interval_8,
  // processor link
  external_controller_request_link_if.ctrl_end           link,
  // AXI4-Lite slave
  input  wire  logic [ADDR_W-1:0] awaddr,
  input  wire  logic              awvalid,
  output logic                    awready,
  input  wire  logic [31:0]       wdata,
  input  wire  logic [3:0]        wstrb,
  input  wire  logic              wvalid,
  output logic                    wready,
  output logic [1:0]              bresp,
  output logic                    bvalid,
  input  wire  logic              bready,
  input  wire  logic [ADDR_W-1:0] araddr,
  input  wire  logic              arvalid,
  output logic                    arready,
  output logic [31:0]             rdata,
  output logic [1:0]              rresp,
  output logic                    rvalid,
  input  wire  logic              rready
);
  import external_controller_request_pkg::*;

  // decode looks at the low four address bits
  if (LINES != 8 || ADDR_W < 4) begin : g_check
    $error("priority_controller needs LINES 8 and ADDR_W 4 or more");
  end

  ctrl_state_t s;
  ctrl_state_t n;
  logic [3:0]  req_top;
  logic [3:0]  isr_top;

  // lowest index wins; bit 3 flags that nothing is set
  function automatic logic [3:0] top(input logic [7:0] v);
    top = 4'h8;
    for (int i = 7; i >= 0; i--) begin
      if (v[i]) begin
        top = {1'b0, 3'(i)};
      end
    end
  endfunction

  function automatic logic [1:0] decode(input logic [ADDR_W-1:0] a);
    if (a[3:0] == `OFS_OPWORD) begin
      decode = 2'h0;
    end else if (a[3:0] == `OFS_LINE_MASK) begin
      decode = 2'h1;
    end else begin
      decode = 2'h2;
    end
  endfunction

  //////////////////////////////////////////////////////////////////////
  always_comb begin
    n       = s;
    n.sync1 = request_lines;
    n.sync2 = s.sync1;
    req_top = top(s.sync2 & ~s.mask);
    isr_top = top(s.in_service_reg);

    // write: address and data in either order, response after both
    if (awvalid && s.awready) begin
      n.aw_hold = 1'b1;
      n.aw_sel  = decode(awaddr);
    end
    if (wvalid && s.wready) begin
      n.w_hold = 1'b1;
      n.wdata  = wstrb[0] ? wdata[7:0] : s.wdata;
    end
    if (s.bvalid && bready) begin
      n.bvalid = 1'b0;
    end
    if (s.aw_hold && s.w_hold && !s.bvalid) begin
      n.aw_hold = 1'b0;
      n.w_hold  = 1'b0;
      n.bvalid  = 1'b1;
      n.bresp   = `AXI_OKAY;
      if (s.aw_sel == 2'h0) begin
        if (s.wdata == `EOS_CMD && !isr_top[3]) begin
          n.in_service_reg[isr_top[2:0]] = 1'b0;
        end else if (s.wdata == `READ_PEND_CMD) begin
          n.read_isr = 1'b0;
        end else if (s.wdata == `READ_INSV_CMD) begin
          n.read_isr = 1'b1;
        end
      end else if (s.aw_sel == 2'h1) begin
        n.mask = s.wdata;
      end else begin
        n.bresp = `AXI_SLVERR;
      end
    end
    n.awready = ~n.aw_hold & ~n.bvalid;
    n.wready  = ~n.w_hold & ~n.bvalid;

    // read: one outstanding, answered the cycle after it is taken
    if (s.rvalid && rready) begin
      n.rvalid = 1'b0;
    end
    if (arvalid && s.arready) begin
      n.rvalid = 1'b1;
      n.rresp  = `AXI_OKAY;
      n.rdata  = 32'h0000_0000;
      if (decode(araddr) == 2'h0) begin
        n.rdata[7:0] = s.read_isr ? s.in_service_reg : s.sync2;
      end else if (decode(araddr) == 2'h1) begin
        n.rdata[7:0] = s.mask;
      end else begin
        n.rresp = `AXI_SLVERR;
      end
    end
    n.arready = ~n.rvalid;

    // fully nested: a line requests only above the top in-service one
    n.req = ~req_top[3] & (req_top < isr_top);

    // each strobe low cycle loads the next byte for the processor
    if (!link.ack_strobe_n) begin
      if (s.byte_idx == 2'h0) begin
        n.line           = req_top[3] ? 3'h7 : req_top[2:0];
        n.in_service_reg[n.line]    = 1'b1;
        n.data           = `CALL_OPCODE;
        n.req            = 1'b0;
        n.byte_idx       = 2'h1;
      end else if (s.byte_idx == 2'h1) begin
        // routine placement by interval from vector_base and interval_8
        n.data     = interval_8 ? {vector_base[7:6], s.line, 3'h0}
                                : {vector_base[7:5], s.line, 2'h0};
        n.byte_idx = 2'h2;
      end else begin
        n.data     = vector_base[15:8];
        n.byte_idx = 2'h0;
      end
    end

    if (!clk_en) begin
      n = s;
    end
  end

  //////////////////////////////////////////////////////////////////////
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s         <= '0;
      s.mask    <= `LINE_MASK_RST;
      s.awready <= 1'b1;
      s.wready  <= 1'b1;
      s.arready <= 1'b1;
    end else begin
      s <= n;
    end
  end

  assign link.request = s.req;
  assign link.data    = s.data;
  assign awready      = s.awready;
  assign wready       = s.wready;
  assign bvalid       = s.bvalid;
  assign bresp        = s.bresp;
  assign arready      = s.arready;
  assign rvalid       = s.rvalid;
  assign rdata        = s.rdata;
  assign rresp        = s.rresp;
endmodule

// [sim/external_controller_request_link_monitor.sv]
// checker of the acknowledge link between the two ends
// assumes link signals, shared clock and reset as plain inputs
`timescale 1ns/100ps
`include "external_controller_request_params.svh"
module external_controller_request_link_monitor (
  // clock and reset
  input wire logic       aclk,
  input wire logic       aresetn,
  // link
  input wire logic       request,
  input wire logic       ack_strobe_n,
  input wire logic [7:0] data
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  ////////////////////////////////////////////////////////////////////////
  // only the first strobe of a call sees request still high
  sequence first_strobe;
    request && $fell(ack_strobe_n);
  endsequence
  sequence two_more;
    ack_strobe_n ##1 !ack_strobe_n ##1 ack_strobe_n ##1 !ack_strobe_n
    ##1 ack_strobe_n;
  endsequence

  ////////////////////////////////////////////////////////////////////////
  strobe_pulse_a:
    assert property ($fell(ack_strobe_n) |=> ack_strobe_n)
    else $error("strobe low over one cycle");
  three_strobes_a:
    assert property (first_strobe |=> two_more)
    else $error("strobe train not three pulses");
  opcode_first_a:
    assert property (first_strobe |=> data == `CALL_OPCODE)
    else $error("first byte not call opcode");
  byte_held_a:
    assert property (first_strobe |-> ##2 $stable(data))
    else $error("byte changed under strobe");
  low_aligned_a:
    assert property (first_strobe |-> ##3 data[1:0] == 2'h0)
    else $error("routine address not aligned");
  request_drop_a:
    assert property (first_strobe |=> !request)
    else $error("request kept after first strobe");
  strobe_cause_a:
    assert property ($fell(ack_strobe_n) |->
      request || $past(request, 2) || $past(request, 4))
    else $error("strobe without a request");
  reset_idle_a:
    assert property ($rose(aresetn) |-> ack_strobe_n && !request)
    else $error("link busy out of reset");
endmodule

// [sim/cpu_interrupt_entry_tb.sv]
// bench joining processor entry logic and priority controller
// assumes rtl/ on the include path; both ends face each other
`timescale 1ns/100ps
`include "external_controller_request_params.svh"
module cpu_interrupt_entry_tb;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  // pins: nonmaskable, edge, high, low
  logic [3:0]  pins = 4'h0;
  logic        instr_last_cycle = 1'b0;
  logic        enable_set = 1'b0;
  logic        enable_clear = 1'b0;
  logic        set_mask_instruction = 1'b0;
  logic [7:0]  set_mask_data = 8'h00;
  logic        read_mask_instruction = 1'b0;
  logic        restart_taken, push_pc, call_done, interrupt_enable;
  logic [15:0] restart_vector, call_target;
  logic [7:0]  call_opcode, read_mask_data;
  logic [7:0]  request_lines = 8'h00;
  logic        interval_8 = 1'b1;
  logic [3:0]  awaddr = 4'h0, araddr = 4'h0;
  logic [31:0] wdata = 32'h0, rdata;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic        arvalid = 1'b0, rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp;
  int          fail_count = 0, samples_checked = 0, cycles = 0;

  always #5 aclk = ~aclk;
  external_controller_request_link_if external_controller_request_link_if_i ();
  cpu_interrupt_entry cpu_interrupt_entry_i (
    .aclk, .aresetn, .clk_en(1'b1),
    .nonmaskable_request(pins[3]), .edge_restart_request(pins[2]),
    .level_restart_high(pins[1]), .level_restart_low(pins[0]),
    .link(external_controller_request_link_if_i.cpu_end), .instr_last_cycle, .enable_set,
    .enable_clear, .set_mask_instruction, .set_mask_data,
    .read_mask_instruction, .restart_taken, .restart_vector, .push_pc,
    .call_done, .call_opcode, .call_target, .read_mask_data,
    .interrupt_enable);
  priority_controller priority_controller_i (
    .aclk, .aresetn, .clk_en(1'b1), .request_lines,
    .vector_base(16'h4000), .interval_8,
    .link(external_controller_request_link_if_i.ctrl_end), .awaddr, .awvalid, .awready, .wdata,
    .wstrb(4'hF), .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
    .arvalid, .arready, .rdata, .rresp, .rvalid, .rready);
  external_controller_request_link_monitor external_controller_request_link_monitor_i (
    .aclk, .aresetn, .request(external_controller_request_link_if_i.request),
    .ack_strobe_n(external_controller_request_link_if_i.ack_strobe_n),
    .data(external_controller_request_link_if_i.data));

  ////////////////////////////////////////////////////////////////////////
  task automatic test_done;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // the whole run needs well under a thousand cycles
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      fail_count++;
      test_done();
    end
  end
  task automatic chk(input string n, input logic [15:0] got, exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", n, exp, got);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask
  task automatic smi(input logic [7:0] d);
    set_mask_instruction <= 1'b1;
    set_mask_data <= d;
    @(posedge aclk);
    set_mask_instruction <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic en;
    enable_set <= 1'b1;
    @(posedge aclk);
    enable_set <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic rmi(input logic e);
    read_mask_instruction <= 1'b1;
    @(posedge aclk);
    read_mask_instruction <= 1'b0;
    @(posedge aclk);
    chk("read enable", 16'(read_mask_data[3]), 16'(e));
  endtask
  task automatic take(input logic t, input logic [15:0] v);
    instr_last_cycle <= 1'b1;
    @(posedge aclk);
    instr_last_cycle <= 1'b0;
    @(posedge aclk);
    chk("taken", 16'(restart_taken), 16'(t));
    if (t) begin
      chk("vector", restart_vector, v);
      chk("enable", 16'(interrupt_enable), 16'h0);
    end
    @(posedge aclk);
  endtask
  task automatic axw(input logic [3:0] a, input logic [7:0] d,
                     input logic [1:0] er);
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    chk("bresp", 16'(bresp), 16'(er));
    @(posedge aclk);
  endtask
  task automatic axr(input logic [3:0] a, input logic [7:0] d,
                     input logic [1:0] er);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
    chk("rdata", rdata[15:0], 16'(d));
    chk("rresp", 16'(rresp), 16'(er));
    @(posedge aclk);
  endtask

  ////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    chk("enable", 16'(interrupt_enable), 16'h0);
    axr(4'h4, 8'hFF, 2'h0);
    axr(4'hC, 8'h00, 2'h2);
    $display("reset test done");
  endtask
  task automatic t_restart;
    logic [15:0] v [3] = '{16'h003C, 16'h0034, 16'h002C};
    smi(8'h08);
    en();
    for (int i = 0; i < 3; i++) begin
      pins[2-i] <= 1'b1;
      @(posedge aclk);
      if (i == 0) pins[2] <= 1'b0;
      cyc(3);
      take(1'b1, v[i]);
      pins[2-i] <= 1'b0;
      en();
    end
    smi(8'h0C);
    pins[2] <= 1'b1;
    @(posedge aclk);
    pins[2] <= 1'b0;
    cyc(4);
    take(1'b0, 16'h0);
    enable_clear <= 1'b1;
    pins[1] <= 1'b1;
    @(posedge aclk);
    enable_clear <= 1'b0;
    cyc(4);
    take(1'b0, 16'h0);
    pins[1] <= 1'b0;
    smi(8'h08);
    en();
    take(1'b1, 16'h003C);
    $display("restart test done");
  endtask
  task automatic t_prio;
    en();
    pins <= 4'hF;
    @(posedge aclk);
    pins <= 4'h3;
    cyc(4);
    take(1'b1, 16'h0024);
    rmi(1'b1);
    rmi(1'b0);
    en();
    take(1'b1, 16'h003C);
    en();
    take(1'b1, 16'h0034);
    pins[1] <= 1'b0;
    en();
    take(1'b1, 16'h002C);
    pins[0] <= 1'b0;
    enable_clear <= 1'b1;
    pins[3] <= 1'b1;
    @(posedge aclk);
    enable_clear <= 1'b0;
    pins[3] <= 1'b0;
    cyc(4);
    take(1'b1, 16'h0024);
    $display("priority test done");
  endtask
  task automatic ext_call(input logic [15:0] t);
    logic pushed;
    pushed = 1'b0;
    en();
    cyc(6);
    chk("idle strobe", 16'(external_controller_request_link_if_i.ack_strobe_n), 16'h1);
    instr_last_cycle <= 1'b1;
    @(posedge aclk);
    instr_last_cycle <= 1'b0;
    repeat (20) begin
      @(posedge aclk);
      if (push_pc === 1'b1) pushed = 1'b1;
      if (call_done === 1'b1) break;
    end
    chk("push", 16'(pushed), 16'h1);
    chk("opcode", 16'(call_opcode), 16'h00CD);
    chk("target", call_target, t);
    chk("enable", 16'(interrupt_enable), 16'h0);
  endtask
  task automatic t_ext;
    axw(4'h4, 8'hF7, 2'h0);
    axr(4'h4, 8'hF7, 2'h0);
    axw(4'h8, 8'h00, 2'h2);
    request_lines[3] <= 1'b1;
    ext_call(16'h4018);
    axw(4'h0, 8'h0B, 2'h0);
    axr(4'h0, 8'h08, 2'h0);
    axw(4'h0, 8'h0A, 2'h0);
    axr(4'h0, 8'h08, 2'h0);
    request_lines[3] <= 1'b0;
    axw(4'h0, 8'h20, 2'h0);
    axw(4'h0, 8'h0B, 2'h0);
    axr(4'h0, 8'h00, 2'h0);
    // 4-byte spacing of routines
    interval_8 <= 1'b0;
    request_lines[3] <= 1'b1;
    ext_call(16'h400C);
    request_lines[3] <= 1'b0;
    axw(4'h0, 8'h20, 2'h0);
    axr(4'h0, 8'h00, 2'h0);
    $display("external test done");
  endtask

  initial begin
    cyc(4);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset();
    t_restart();
    t_prio();
    t_ext();
    test_done();
  end
endmodule
